// File: pkg/mnp_defs.svh
// Constants for the multiply, negate and pop execution block.
// Assumes inclusion by bare name; definitions only.
`ifndef MNP_DEFS_SVH
`define MNP_DEFS_SVH

// APB byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_WREG 12'h008
`define OFS_BANK 12'h00C
`define OFS_PROD_LOW 12'h010
`define OFS_PROD_HIGH 12'h014
`define OFS_INDEX 12'h018
`define OFS_INSTR 12'h01C

// Status and control bit positions
`define ST_CARRY 0
`define ST_HALF 1
`define ST_ZERO 2
`define ST_WRAP 3
`define ST_NEG 4
`define ST_BUSY 8
`define CTRL_EXT 0

// Reset values
`define RST_BYTE 8'h00
`define RST_INDEX 14'h0000
`define RST_INSTR 16'h0000

// Opcode fields
`define OPC_MULL 8'h0D
`define OPC_MULF 7'b000_0001
`define OPC_NEG_FILE 7'b011_0110
`define OPC_POP 16'h0006
`define ACC_BIT 8

// Addressing
`define ILO_LIMIT 8'h5F
`define ACC_LOW_BASE 14'h0000
`define ACC_HIGH_BASE 14'h3F00
`define BANK_WIDTH 6

`endif

// File: pkg/mnp_pkg.sv
// Types shared by the execution block and its arithmetic unit.
// Assumes nothing of its surroundings.
package mnp_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [13:0] daddr_t;
   typedef enum logic [2:0]
   {
      PH_IDLE = 3'b000,
      PH_Q1 = 3'b001,
      PH_Q2 = 3'b010,
      PH_Q3 = 3'b011,
      PH_Q4 = 3'b100
   } phase_t;
   typedef enum logic [2:0]
   {
      OP_NONE = 3'b000,
      OP_MULL = 3'b001,
      OP_MULF = 3'b010,
      OP_NEG = 3'b011,
      OP_POP = 3'b100
   } op_t;
endpackage

// File: src/mnp_arith.sv
// Arithmetic unit: unsigned 8x8 multiply and two's complement negate.
// Assumes purely combinational use by the execution block.
`timescale 1ns/100ps
`include "mnp_defs.svh"
module mnp_arith
(
   // Operands
   input wire mnp_pkg::byte_t acc_i,
   input wire mnp_pkg::byte_t opnd_i,
   // Results
   output logic [15:0] product_o,
   output mnp_pkg::byte_t neg_o,
   output logic [4:0] flags_o
);
   import mnp_pkg::*;
   logic [8:0] sum;
   logic [4:0] low_sum;
   always_comb
   begin
      product_o = 16'(acc_i) * 16'(opnd_i);
      sum = {1'b0, ~opnd_i} + 9'h001;
      low_sum = {1'b0, ~opnd_i[3:0]} + 5'h01;
      neg_o = sum[7:0];
      flags_o = 5'h00;
      flags_o[`ST_CARRY] = sum[8];
      flags_o[`ST_HALF] = low_sum[4];
      flags_o[`ST_ZERO] = (sum[7:0] == 8'h00);
      // Only 80h wraps back onto itself
      flags_o[`ST_WRAP] = opnd_i[7] & sum[7];
      flags_o[`ST_NEG] = sum[7];
   end
endmodule

// File: src/mnp_exec.sv
// Execution block for multiply-literal, multiply-file, negate and pop.
// Assumes an APB master, a data memory answering reads in the cycle of the read strobe,
// and a return stack that discards its top on one pop pulse.
//
// Functional notes
// - Multiply literal: accumulator times literal, unsigned
// - Full product into high and low bytes
// - Multiplies keep flags and accumulator unchanged
// - Zero product never flagged; zero flag kept
// - Multiply file: accumulator times register, unsigned
// - Access bit selects access bank or bank
// - Extended set: low addresses use indexed offset
// - Negate register, update five flags from result
// - Pop discards stack top, flags untouched
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/100ps
`include "mnp_defs.svh"
module mnp_exec
(
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Data memory
   output mnp_pkg::daddr_t DMEM_ADDR_O,
   output logic DMEM_RE_O,
   output logic DMEM_WE_O,
   output mnp_pkg::byte_t DMEM_WDATA_O,
   input wire mnp_pkg::byte_t DMEM_RDATA_I,
   // Return stack
   output logic STACK_POP_O
);
   import mnp_pkg::*;

   phase_t phase, next_phase;
   op_t op, next_op;
   logic [15:0] instr, next_instr;
   logic ext_en, next_ext_en;
   logic [4:0] status, next_status;
   byte_t wreg, next_wreg;
   byte_t bank_select, next_bank_select;
   byte_t product_low, next_product_low;
   byte_t product_high, next_product_high;
   daddr_t index_base, next_index_base;
   byte_t opnd, next_opnd;
   daddr_t addr, next_addr;
   logic rd_en, next_rd_en;
   logic wr_en, next_wr_en;
   byte_t wdata, next_wdata;
   logic pop, next_pop;
   logic [31:0] rdata, next_rdata;
   logic ready, next_ready;
   logic err, next_err;

   logic [15:0] product;
   byte_t neg_val;
   logic [4:0] neg_flags;
   logic setup, wr_acc, mapped;
   daddr_t file_addr;

   mnp_arith u_arith
   (
      .acc_i(wreg),
      .opnd_i(opnd),
      .product_o(product),
      .neg_o(neg_val),
      .flags_o(neg_flags)
   );

   // Effective file address of the latched instruction
   always_comb
   begin
      file_addr = {6'h00, instr[7:0]};
      if (instr[`ACC_BIT])
      begin
         file_addr = {bank_select[`BANK_WIDTH-1:0], instr[7:0]};
      end
      else if (ext_en && (instr[7:0] <= `ILO_LIMIT))
      begin
         file_addr = 14'(index_base + {6'h00, instr[7:0]});
      end
      else if (instr[7:0] <= `ILO_LIMIT)
      begin
         file_addr = `ACC_LOW_BASE | {6'h00, instr[7:0]};
      end
      else
      begin
         file_addr = `ACC_HIGH_BASE | {6'h00, instr[7:0]};
      end
   end

   // Register access decode
   always_comb
   begin
      setup = PSEL_I && !PENABLE_I;
      wr_acc = PSEL_I && PENABLE_I && PWRITE_I && ready;
      unique case (PADDR_I)
         `OFS_CTRL, `OFS_STATUS, `OFS_WREG, `OFS_BANK, `OFS_PROD_LOW, `OFS_PROD_HIGH,
         `OFS_INDEX, `OFS_INSTR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
      next_ready = setup;
      next_err = setup && !mapped;
      next_rdata = rdata;
      if (setup)
      begin
         next_rdata = 32'h0000_0000;
         unique case (PADDR_I)
            `OFS_CTRL: next_rdata[`CTRL_EXT] = ext_en;
            `OFS_STATUS: next_rdata = {23'h00_0000, phase != PH_IDLE, 3'h0, status};
            `OFS_WREG: next_rdata[7:0] = wreg;
            `OFS_BANK: next_rdata[7:0] = bank_select;
            `OFS_PROD_LOW: next_rdata[7:0] = product_low;
            `OFS_PROD_HIGH: next_rdata[7:0] = product_high;
            `OFS_INDEX: next_rdata[13:0] = index_base;
            `OFS_INSTR: next_rdata[15:0] = instr;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Phase sequencer and datapath
   always_comb
   begin
      next_phase = phase;
      next_op = op;
      next_instr = instr;
      next_ext_en = ext_en;
      next_status = status;
      next_wreg = wreg;
      next_bank_select = bank_select;
      next_product_low = product_low;
      next_product_high = product_high;
      next_index_base = index_base;
      next_opnd = opnd;
      next_addr = addr;
      next_rd_en = 1'b0;
      next_wr_en = 1'b0;
      next_wdata = wdata;
      next_pop = 1'b0;
      // Software writes first; the running instruction overrides below
      if (wr_acc)
      begin
         unique case (PADDR_I)
            `OFS_CTRL: next_ext_en = PWDATA_I[`CTRL_EXT];
            `OFS_STATUS: next_status = PWDATA_I[4:0];
            `OFS_WREG: next_wreg = PWDATA_I[7:0];
            `OFS_BANK: next_bank_select = {2'b00, PWDATA_I[`BANK_WIDTH-1:0]};
            `OFS_PROD_LOW: next_product_low = PWDATA_I[7:0];
            `OFS_PROD_HIGH: next_product_high = PWDATA_I[7:0];
            `OFS_INDEX: next_index_base = PWDATA_I[13:0];
            `OFS_INSTR:
            begin
               // One word per instruction; ignored while busy
               if (phase == PH_IDLE)
               begin
                  next_instr = PWDATA_I[15:0];
                  next_phase = PH_Q1;
               end
            end
            default: next_phase = phase;
         endcase
      end
      unique case (phase)
         PH_IDLE: next_op = op;
         PH_Q1:
         begin
            // Decode
            if (instr[15:8] == `OPC_MULL)
            begin
               next_op = OP_MULL;
               next_opnd = instr[7:0];
            end
            else if (instr[15:9] == `OPC_MULF)
            begin
               next_op = OP_MULF;
            end
            else if (instr[15:9] == `OPC_NEG_FILE)
            begin
               next_op = OP_NEG;
            end
            else if (instr == `OPC_POP)
            begin
               next_op = OP_POP;
            end
            else
            begin
               next_op = OP_NONE;
            end
            next_addr = file_addr;
            next_rd_en = (instr[15:9] == `OPC_MULF) || (instr[15:9] == `OPC_NEG_FILE);
            next_phase = PH_Q2;
         end
         PH_Q2:
         begin
            // Operand read returns now
            if (op == OP_MULF || op == OP_NEG)
            begin
               next_opnd = DMEM_RDATA_I;
            end
            next_phase = PH_Q3;
         end
         PH_Q3:
         begin
            if (op == OP_NEG)
            begin
               next_wdata = neg_val;
               next_wr_en = 1'b1;
            end
            next_pop = (op == OP_POP);
            next_phase = PH_Q4;
         end
         PH_Q4:
         begin
            // Result write; multiplies touch neither flags nor accumulator
            if (op == OP_MULL || op == OP_MULF)
            begin
               next_product_high = product[15:8];
               next_product_low = product[7:0];
            end
            if (op == OP_NEG)
            begin
               next_status = neg_flags;
            end
            next_phase = PH_IDLE;
         end
         default: next_phase = PH_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         phase <= PH_IDLE;
         op <= OP_NONE;
         instr <= `RST_INSTR;
         ext_en <= 1'b0;
         status <= 5'h00;
         wreg <= `RST_BYTE;
         bank_select <= `RST_BYTE;
         product_low <= `RST_BYTE;
         product_high <= `RST_BYTE;
         index_base <= `RST_INDEX;
         opnd <= `RST_BYTE;
         addr <= `RST_INDEX;
         rd_en <= 1'b0;
         wr_en <= 1'b0;
         wdata <= `RST_BYTE;
         pop <= 1'b0;
         rdata <= 32'h0000_0000;
         ready <= 1'b0;
         err <= 1'b0;
      end
      else
      begin
         phase <= next_phase;
         op <= next_op;
         instr <= next_instr;
         ext_en <= next_ext_en;
         status <= next_status;
         wreg <= next_wreg;
         bank_select <= next_bank_select;
         product_low <= next_product_low;
         product_high <= next_product_high;
         index_base <= next_index_base;
         opnd <= next_opnd;
         addr <= next_addr;
         rd_en <= next_rd_en;
         wr_en <= next_wr_en;
         wdata <= next_wdata;
         pop <= next_pop;
         rdata <= next_rdata;
         ready <= next_ready;
         err <= next_err;
      end
   end

   always_comb
   begin
      PRDATA_O = rdata;
      PREADY_O = ready;
      PSLVERR_O = err;
      DMEM_ADDR_O = addr;
      DMEM_RE_O = rd_en;
      DMEM_WE_O = wr_en;
      DMEM_WDATA_O = wdata;
      STACK_POP_O = pop;
   end
endmodule

// File: tb/mnp_exec_assertions.sv
// Checker for the execution block: strobe widths and the negate path.
// Assumes a bind to mnp_exec; memory answers within the read cycle.
`timescale 1ns/100ps
module mnp_exec_assertions
(
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   // Memory and stack
   input wire mnp_pkg::daddr_t DMEM_ADDR_O,
   input wire logic DMEM_RE_O,
   input wire logic DMEM_WE_O,
   input wire mnp_pkg::byte_t DMEM_WDATA_O,
   input wire mnp_pkg::byte_t DMEM_RDATA_I,
   input wire logic STACK_POP_O
);
   import mnp_pkg::*;
   default clocking @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RST_I);
   chk_read_pulse: assert property (DMEM_RE_O |=> !DMEM_RE_O)
      else $error("read strobe too long");
   chk_write_pulse: assert property (DMEM_WE_O |=> !DMEM_WE_O)
      else $error("write strobe too long");
   chk_pop_pulse: assert property (STACK_POP_O |=> !STACK_POP_O)
      else $error("pop strobe too long");
   chk_write_after_read: assert property (DMEM_WE_O |-> $past(DMEM_RE_O, 2))
      else $error("write not two cycles after read");
   chk_neg_value: assert property (DMEM_WE_O |->
      DMEM_WDATA_O == 8'(~$past(DMEM_RDATA_I, 2) + 8'd1))
      else $error("negate result wrong");
   chk_neg_addr: assert property (DMEM_WE_O |-> DMEM_ADDR_O == $past(DMEM_ADDR_O, 2))
      else $error("negate writes another address");
   chk_pop_quiet: assert property (STACK_POP_O |->
      !DMEM_WE_O && !$past(DMEM_RE_O, 2))
      else $error("pop touches memory");
   chk_read_alone: assert property (DMEM_RE_O |-> !DMEM_WE_O && !STACK_POP_O)
      else $error("read overlaps other strobe");
endmodule
bind mnp_exec mnp_exec_assertions chk_u (.SYS_CLK_I, .RST_I, .DMEM_ADDR_O, .DMEM_RE_O,
   .DMEM_WE_O, .DMEM_WDATA_O, .DMEM_RDATA_I, .STACK_POP_O);

// File: tb/mnp_mem_model.sv
// Data memory answering within the read cycle, and a return stack.
// Assumes one-cycle strobes from the execution block.
`timescale 1ns/100ps
module mnp_mem_model
(
   // Clock
   input wire logic clk_i,
   // Memory port
   input wire mnp_pkg::daddr_t addr_i,
   input wire logic re_i,
   input wire logic we_i,
   input wire mnp_pkg::byte_t wdata_i,
   output mnp_pkg::byte_t rdata_o,
   // Stack
   input wire logic pop_i
);
   import mnp_pkg::*;
   byte_t mem [0:16383];
   byte_t last = 8'h5A;
   int depth = 31;
   // Idle bus toggles so a stale sample cannot pass
   assign rdata_o = re_i ? mem[addr_i] : ~last;
   always @(posedge clk_i)
   begin
      last <= rdata_o;
      if (we_i)
         mem[addr_i] <= wdata_i;
      if (pop_i)
         depth <= depth - 1;
   end
endmodule

// File: tb/test_multiply_negate_pop_exec.sv
// Self-checking bench: random multiply, negate and pop instructions over APB.
// Assumes the memory model answers reads in the read cycle.
`timescale 1ns/100ps
`include "mnp_defs.svh"
module test_multiply_negate_pop_exec;
   import mnp_pkg::*;
   logic clk, rst, psel, pen, pw, re, we, pop, prdy, perr, er, a, x;
   logic [11:0] pa;
   logic [31:0] pwd, prd, q, h;
   daddr_t ma, e, ix;
   byte_t wd, rd, w, k, f, v, s;
   logic [5:0] b;
   int fails, total_checks, seed, i, op, d0;
   mnp_exec dut_u (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .DMEM_ADDR_O(ma), .DMEM_RE_O(re), .DMEM_WE_O(we),
      .DMEM_WDATA_O(wd), .DMEM_RDATA_I(rd), .STACK_POP_O(pop));
   mnp_mem_model mem_u (.clk_i(clk), .addr_i(ma), .re_i(re), .we_i(we),
      .wdata_i(wd), .rdata_o(rd), .pop_i(pop));
   initial
   begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", n, ex, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] dt);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1;
      pw <= wr;
      pa <= ad;
      pwd <= dt;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (prdy !== 1'b1 && n < 9)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 9)
         fails++;
      q = prd;
      er = perr;
      psel <= 0;
      pen <= 0;
   endtask
   // Waits on the busy bit rather than a fixed count
   task automatic run(input logic [15:0] ins);
      int n;
      n = 0;
      apb(1, `OFS_INSTR, {16'h0, ins});
      apb(0, `OFS_STATUS, '0);
      while (q[`ST_BUSY] !== 1'b0 && n < 9)
      begin
         apb(0, `OFS_STATUS, '0);
         n++;
      end
      if (n == 9)
         fails++;
   endtask
   function automatic daddr_t ea(input logic aa, input byte_t ff, input logic xx,
      input daddr_t ii, input logic [5:0] bb);
      if (aa)
         return {bb, ff};
      if (ff > 8'h5F)
         return 14'h3F00 + 14'(ff);
      return xx ? ii + 14'(ff) : 14'(ff);
   endfunction
   function automatic logic [31:0] nflags(input byte_t o);
      byte_t r;
      r = 8'(-o);
      return {27'h0, r[7], o == 8'h80, r == 8'h00, o[3:0] == 4'h0, o == 8'h00};
   endfunction
   initial
   begin
      #400000;
      fails++;
      results();
   end
   initial
   begin
      seed = 61;
      rst = 1;
      psel = 0;
      pen = 0;
      pw = 0;
      pa = '0;
      pwd = '0;
      repeat (2) @(posedge clk);
      rst <= 0;
      apb(0, `OFS_STATUS, '0);
      chk("status reset", '0, q);
      apb(0, 12'h020, '0);
      chk("unmapped error", 1, {31'h0, er});
      chk("unmapped read", '0, q);
      // Second instruction lands in the third phase of the first
      apb(1, `OFS_WREG, 32'h0000_0003);
      apb(1, `OFS_INSTR, {16'h0, `OPC_MULL, 8'h05});
      run({`OPC_MULL, 8'h07});
      apb(0, `OFS_PROD_LOW, '0);
      chk("busy refusal", 32'h0000_000F, q);
      for (i = 0; i < 24; i++)
      begin
         op = i % 4;
         w = (i == 0) ? 8'hFF : 8'($random(seed));
         k = (i == 0) ? 8'hFF : (i == 4) ? 8'h00 : 8'($random(seed));
         v = (i == 2) ? 8'h00 : (i == 6) ? 8'h80 : 8'($random(seed));
         f = 8'($random(seed));
         a = 1'($random(seed));
         x = 1'($random(seed));
         b = 6'($random(seed));
         ix = 14'($random(seed));
         s = {3'b000, 5'($random(seed))};
         e = ea(a, f, x, ix, b);
         mem_u.mem[e] = v;
         apb(1, `OFS_CTRL, {31'h0, x});
         apb(1, `OFS_WREG, {24'h0, w});
         apb(1, `OFS_BANK, {26'h0, b});
         apb(1, `OFS_INDEX, {18'h0, ix});
         apb(1, `OFS_STATUS, {24'h0, s});
         d0 = mem_u.depth;
         case (op)
            0: run({`OPC_MULL, k});
            1: run({`OPC_MULF, a, f});
            2: run({`OPC_NEG_FILE, a, f});
            default: run(`OPC_POP);
         endcase
         chk("status", op == 2 ? nflags(v) : {24'h0, s}, q);
         apb(0, `OFS_PROD_HIGH, '0);
         h = q;
         apb(0, `OFS_PROD_LOW, '0);
         if (op < 2)
            chk("product", {8'h0, w} * {8'h0, op == 0 ? k : v}, {h[23:0], q[7:0]});
         apb(0, `OFS_WREG, '0);
         chk("wreg", {24'h0, w}, q);
         chk("slave error", '0, {31'h0, er});
         chk("memory", op == 2 ? 8'(-v) : v, mem_u.mem[e]);
         chk("stack depth", d0 - (op == 3), mem_u.depth);
         $display("test %0d op %0d done", i, op);
      end
      results();
   end
endmodule
